// ### rtl/oamd_consts.vh
/*
  Constants for the operand addressing-mode decoder: mode codes,
  prebyte values, opcode column codes and field widths.
  Included by the rtl files and by the dv checker and bench; definitions only.
*/
`ifndef OAMD_CONSTS_VH
`define OAMD_CONSTS_VH

// Prefix bytes
`define OAMD_PRE_Y          8'h90
`define OAMD_PRE_IND        8'h92
`define OAMD_PRE_IND_Y      8'h91

// Mode codes, 17 modes
`define OAMD_MODE_W         5
`define OAMD_M_INH          5'h00
`define OAMD_M_IMM          5'h01
`define OAMD_M_DIR_S        5'h02
`define OAMD_M_DIR_L        5'h03
`define OAMD_M_IDX_0        5'h04
`define OAMD_M_IDX_S        5'h05
`define OAMD_M_IDX_L        5'h06
`define OAMD_M_IND_S        5'h07
`define OAMD_M_IND_L        5'h08
`define OAMD_M_INDX_S       5'h09
`define OAMD_M_INDX_L       5'h0A
`define OAMD_M_REL_D        5'h0B
`define OAMD_M_REL_I        5'h0C
`define OAMD_M_BIT_D        5'h0D
`define OAMD_M_BIT_I        5'h0E
`define OAMD_M_BITREL_D     5'h0F
`define OAMD_M_BITREL_I     5'h10

// Opcode column field, high nibble
`define OAMD_COL_IMM        4'hA
`define OAMD_COL_DIR_S      4'hB
`define OAMD_COL_DIR_L      4'hC
`define OAMD_COL_IDX_L      4'hD
`define OAMD_COL_IDX_S      4'hE
`define OAMD_COL_IDX_0      4'hF
`define OAMD_COL_RMW_DIR    4'h3
`define OAMD_COL_RMW_IDX_S  4'h6
`define OAMD_COL_RMW_IDX_0  4'h7
`define OAMD_COL_BTJ        4'h0
`define OAMD_COL_BSR        4'h1
`define OAMD_COL_JR         4'h2

// Widths
`define OAMD_ADDR_W         16
`define OAMD_DATA_W         8
`define OAMD_CNT_W          2

`endif

// ### rtl/oamd_mode_table.v
/*
  Combinational opcode-to-mode lookup with prefix adjustment.
  Assumes the opcode and latched prefix flags are stable in the
  caller's clock domain; no state held here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "oamd_consts.vh"

module oamd_mode_table (
  // Instruction
  input  wire [7:0]                 opcode,
  input  wire                       pre_y,
  input  wire                       pre_ind,
  input  wire                       pre_ind_y,
  // Decoded
  output reg  [`OAMD_MODE_W-1:0]    mode,
  output reg                        use_y,
  output reg                        short_only
);

  always @* begin
    mode       = `OAMD_M_INH;
    use_y      = pre_y | pre_ind_y;
    short_only = 1'b0;
    case (opcode[7:4])
      `OAMD_COL_IMM:   mode = `OAMD_M_IMM;
      `OAMD_COL_DIR_S: mode = pre_ind ? `OAMD_M_IND_S : `OAMD_M_DIR_S;
      `OAMD_COL_DIR_L: mode = pre_ind ? `OAMD_M_IND_L : `OAMD_M_DIR_L;
      `OAMD_COL_IDX_L: mode = (pre_ind | pre_ind_y) ? `OAMD_M_INDX_L : `OAMD_M_IDX_L;
      `OAMD_COL_IDX_S: mode = (pre_ind | pre_ind_y) ? `OAMD_M_INDX_S : `OAMD_M_IDX_S;
      `OAMD_COL_IDX_0: mode = `OAMD_M_IDX_0;
      `OAMD_COL_RMW_DIR: begin
        mode       = pre_ind ? `OAMD_M_IND_S : `OAMD_M_DIR_S;
        short_only = 1'b1;
      end
      `OAMD_COL_RMW_IDX_S: begin
        mode       = (pre_ind | pre_ind_y) ? `OAMD_M_INDX_S : `OAMD_M_IDX_S;
        short_only = 1'b1;
      end
      `OAMD_COL_RMW_IDX_0: begin
        mode       = `OAMD_M_IDX_0;
        short_only = 1'b1;
      end
      `OAMD_COL_BTJ: begin
        mode       = pre_ind ? `OAMD_M_BITREL_I : `OAMD_M_BITREL_D;
        short_only = 1'b1;
      end
      `OAMD_COL_BSR: begin
        mode       = pre_ind ? `OAMD_M_BIT_I : `OAMD_M_BIT_D;
        short_only = 1'b1;
      end
      `OAMD_COL_JR:    mode = pre_ind ? `OAMD_M_REL_I : `OAMD_M_REL_D;
      default:         mode = `OAMD_M_INH;
    endcase
  end

endmodule // oamd_mode_table

`default_nettype wire

// ### rtl/oamd_decoder.v
/*
  Operand addressing-mode decoder and effective-address generator.
  Takes prefix and opcode bytes from the fetch unit, announces the
  operand byte count, gathers operand bytes, reads pointers over a
  simple one-cycle-latency memory read port, and presents the
  effective address. Assumes the fetch unit and memory share CLK_SYS.
*/
// Summary of operation
// [RULE1] Decode seventeen modes in seven families
// [RULE2] Long variants reach full 64 Kbyte space
// [RULE3] Long variants cost more bytes, cycles
// [RULE4] Short addressing page zero; RMW short only
// [RULE5] Inherent is one byte, no operands
// [RULE6] Immediate takes operand from second byte
// [RULE7] Short direct: one byte address
// [RULE8] Long direct: two byte address word
// [RULE9] Indexed: index plus offset, unsigned
// [RULE10] No-offset indexed uses index register alone
// [RULE11] Short indexed: one offset byte, to 1FE
// [RULE12] Long indexed: two byte offset word
// [RULE13] Indirect: page-zero pointer read from memory
// [RULE14] Short indirect: byte pointer, page zero
// [RULE15] Long indirect: word pointer, one byte follows
// [RULE16] Relative target from next-instruction PC, signed
// [RULE17] Prefix 90 selects Y over X
// [RULE18] Prefix 92 turns direct into indirect
// [RULE19] Prefix 91 selects Y for indirect-indexed
// [RULE20] Short index sum 9 bits; long truncates
// [RULE21] Announce operand byte count before address
`timescale 1ns/1ns
`default_nettype none
`include "oamd_consts.vh"

module oamd_decoder #(
  parameter ADDR_W = `OAMD_ADDR_W
) (
  // Clock and control
  input  wire                       CLK_SYS,
  input  wire                       RESET_N,
  input  wire                       CLK_EN,
  // Fetch unit byte stream
  input  wire                       FETCH_VALID,
  input  wire [7:0]                 FETCH_BYTE,
  input  wire [ADDR_W-1:0]          FETCH_PC,
  // Core index registers
  input  wire [7:0]                 REG_X,
  input  wire [7:0]                 REG_Y,
  // Memory read port, data one cycle after request
  output reg                        MEM_RD,
  output reg  [ADDR_W-1:0]          MEM_ADDR,
  input  wire [7:0]                 MEM_DATA,
  // Decode results
  output reg  [`OAMD_MODE_W-1:0]    MODE,
  output reg  [`OAMD_CNT_W-1:0]     OPND_COUNT,
  output reg                        COUNT_VALID,
  output reg                        USE_Y,
  output reg                        SHORT_ONLY,
  output reg                        BUSY,
  output reg  [ADDR_W-1:0]          EA,
  output reg  [7:0]                 IMM_DATA,
  output reg                        EA_VALID
);

  // Sequencer states
  localparam ST_OPC  = 3'd0;
  localparam ST_OPND = 3'd1;
  localparam ST_PTR0 = 3'd2;
  localparam ST_PTR1 = 3'd3;
  localparam ST_PTR2 = 3'd4;
  localparam ST_DONE = 3'd5;

  // Operand byte count per mode
  function [`OAMD_CNT_W-1:0] opnd_bytes;
    input [`OAMD_MODE_W-1:0] m;
    input                    y;
    begin
      case (m)
        `OAMD_M_INH:      opnd_bytes = 2'd0;                              // RULE5
        `OAMD_M_IMM:      opnd_bytes = 2'd1;                              // RULE6
        `OAMD_M_DIR_S:    opnd_bytes = 2'd1;                              // RULE7
        `OAMD_M_DIR_L:    opnd_bytes = 2'd2;                              // RULE8
        `OAMD_M_IDX_0:    opnd_bytes = 2'd0;                              // RULE10
        `OAMD_M_IDX_S:    opnd_bytes = 2'd1;                              // RULE11
        `OAMD_M_IDX_L:    opnd_bytes = 2'd2;                              // RULE12
        `OAMD_M_IND_S:    opnd_bytes = 2'd1;                              // RULE14
        `OAMD_M_IND_L:    opnd_bytes = 2'd1;                              // RULE15
        `OAMD_M_INDX_S:   opnd_bytes = 2'd1;
        `OAMD_M_INDX_L:   opnd_bytes = 2'd1;
        `OAMD_M_REL_D:    opnd_bytes = 2'd1;
        `OAMD_M_REL_I:    opnd_bytes = 2'd1;
        `OAMD_M_BIT_D:    opnd_bytes = 2'd1;
        `OAMD_M_BIT_I:    opnd_bytes = 2'd1;
        `OAMD_M_BITREL_D: opnd_bytes = 2'd2;
        `OAMD_M_BITREL_I: opnd_bytes = 2'd2;
        default:          opnd_bytes = 2'd0;
      endcase
      if (y && m == `OAMD_M_IDX_0)
        opnd_bytes = 2'd0;
    end
  endfunction

  // Modes that go through a page-zero pointer
  function is_indirect;
    input [`OAMD_MODE_W-1:0] m;
    begin
      is_indirect = (m == `OAMD_M_IND_S)  || (m == `OAMD_M_IND_L)  ||
                    (m == `OAMD_M_INDX_S) || (m == `OAMD_M_INDX_L) ||
                    (m == `OAMD_M_REL_I)  || (m == `OAMD_M_BIT_I)  ||
                    (m == `OAMD_M_BITREL_I);
    end
  endfunction

  // Word pointer modes
  function is_word_ptr;
    input [`OAMD_MODE_W-1:0] m;
    begin
      is_word_ptr = (m == `OAMD_M_IND_L) || (m == `OAMD_M_INDX_L);
    end
  endfunction

  // Relative target: signed 8-bit offset on next-instruction PC
  function [ADDR_W-1:0] rel_target;
    input [ADDR_W-1:0] pc;
    input [7:0]        off;
    begin
      rel_target = pc + {{(ADDR_W-8){off[7]}}, off};
    end
  endfunction

  // Nine-bit index sum; no wrap back into page zero
  function [8:0] short_index_sum;
    input [7:0] base;
    input [7:0] idx;
    begin
      short_index_sum = {1'b0, base} + {1'b0, idx};
    end
  endfunction

  // Carry out of the top bit is dropped
  function [ADDR_W-1:0] long_index_sum;
    input [ADDR_W-1:0] base;
    input [7:0]        idx;
    begin
      long_index_sum = base + {{(ADDR_W-8){1'b0}}, idx};
    end
  endfunction

  // Byte address placed in page zero
  function [ADDR_W-1:0] page_zero;
    input [7:0] lo;
    begin
      page_zero = {{(ADDR_W-8){1'b0}}, lo};
    end
  endfunction

  // Sequencer and operand state
  reg  [2:0]                 state_ff;
  reg  [2:0]                 nxt_state;
  reg                        pre_y_ff;
  reg                        pre_ind_ff;
  reg                        pre_ind_y_ff;
  reg  [7:0]                 opcode_ff;
  reg  [1:0]                 left_ff;
  reg  [15:0]                opnd_ff;
  reg  [7:0]                 ptr_hi_ff;
  reg  [ADDR_W-1:0]          pc_next_ff;

  wire [`OAMD_MODE_W-1:0]    tbl_mode;
  wire                       tbl_use_y;
  wire                       tbl_short;
  wire                       is_prefix;
  wire [7:0]                 idx_val;
  reg  [ADDR_W-1:0]          calc_ea;
  reg  [8:0]                 short_sum;

  // Mode table sees the incoming opcode with latched prefixes
  oamd_mode_table u_table (
    .opcode     (FETCH_BYTE),
    .pre_y      (pre_y_ff),
    .pre_ind    (pre_ind_ff),
    .pre_ind_y  (pre_ind_y_ff),
    .mode       (tbl_mode),                                               // RULE1
    .use_y      (tbl_use_y),
    .short_only (tbl_short)
  );

  assign is_prefix = (FETCH_BYTE == `OAMD_PRE_Y) ||
                     (FETCH_BYTE == `OAMD_PRE_IND) ||
                     (FETCH_BYTE == `OAMD_PRE_IND_Y);
  assign idx_val   = USE_Y ? REG_Y : REG_X;                               // RULE17 RULE19

  // Effective address formation from gathered bytes
  always @* begin
    calc_ea   = {ADDR_W{1'b0}};
    short_sum = short_index_sum(idx_val, opnd_ff[7:0]);                   // RULE20
    // Immediate and inherent report address zero
    case (MODE)
      `OAMD_M_IMM:      calc_ea = {ADDR_W{1'b0}};
      `OAMD_M_DIR_S:    calc_ea = page_zero(opnd_ff[7:0]);                // RULE7 RULE4
      `OAMD_M_BIT_D:    calc_ea = page_zero(opnd_ff[7:0]);
      `OAMD_M_BITREL_D: calc_ea = page_zero(opnd_ff[15:8]);
      `OAMD_M_DIR_L:    calc_ea = opnd_ff[ADDR_W-1:0];                    // RULE8 RULE2
      `OAMD_M_IDX_0:    calc_ea = page_zero(idx_val);                     // RULE10
      `OAMD_M_IDX_S:    calc_ea = {{(ADDR_W-9){1'b0}}, short_sum};        // RULE9 RULE11
      `OAMD_M_IDX_L:    calc_ea = long_index_sum(opnd_ff[ADDR_W-1:0], idx_val); // RULE12 RULE20
      `OAMD_M_REL_D:    calc_ea = rel_target(pc_next_ff, opnd_ff[7:0]);   // RULE16
      default:          calc_ea = {ADDR_W{1'b0}};
    endcase
  end

  // Bytes offered in pointer and done states are dropped
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OPC:
        if (FETCH_VALID && !is_prefix)
          nxt_state = (opnd_bytes(tbl_mode, tbl_use_y) == 2'd0) ? ST_DONE : ST_OPND;
      ST_OPND:
        if (FETCH_VALID && left_ff == 2'd1)
          nxt_state = is_indirect(MODE) ? ST_PTR0 : ST_DONE;              // RULE13
      ST_PTR0: nxt_state = ST_PTR1;
      ST_PTR1: nxt_state = is_word_ptr(MODE) ? ST_PTR2 : ST_DONE;
      ST_PTR2: nxt_state = ST_DONE;
      ST_DONE: nxt_state = ST_OPC;
      default: nxt_state = ST_OPC;
    endcase
  end

  // Outside reset, CLK_EN low freezes every register
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      state_ff     <= ST_OPC;
      pre_y_ff     <= 1'b0;
      pre_ind_ff   <= 1'b0;
      pre_ind_y_ff <= 1'b0;
      opcode_ff    <= 8'h00;
      left_ff      <= 2'd0;
      opnd_ff      <= 16'h0000;
      ptr_hi_ff    <= 8'h00;
      pc_next_ff   <= {ADDR_W{1'b0}};
      MEM_RD       <= 1'b0;
      MEM_ADDR     <= {ADDR_W{1'b0}};
      MODE         <= `OAMD_M_INH;
      OPND_COUNT   <= 2'd0;
      COUNT_VALID  <= 1'b0;
      USE_Y        <= 1'b0;
      SHORT_ONLY   <= 1'b0;
      BUSY         <= 1'b0;
      EA           <= {ADDR_W{1'b0}};
      IMM_DATA     <= 8'h00;
      EA_VALID     <= 1'b0;
    end else if (CLK_EN) begin
      state_ff    <= nxt_state;
      COUNT_VALID <= 1'b0;
      EA_VALID    <= 1'b0;
      MEM_RD      <= 1'b0;
      case (state_ff)
        ST_OPC:
          if (FETCH_VALID) begin
            if (is_prefix) begin
              // A later prefix replaces an earlier one
              pre_y_ff     <= (FETCH_BYTE == `OAMD_PRE_Y);                // RULE17
              pre_ind_ff   <= (FETCH_BYTE == `OAMD_PRE_IND);              // RULE18
              pre_ind_y_ff <= (FETCH_BYTE == `OAMD_PRE_IND_Y);            // RULE19
              BUSY         <= 1'b1;
            end else begin
              opcode_ff   <= FETCH_BYTE;
              MODE        <= tbl_mode;
              USE_Y       <= tbl_use_y;
              SHORT_ONLY  <= tbl_short;                                   // RULE4
              OPND_COUNT  <= opnd_bytes(tbl_mode, tbl_use_y);             // RULE21 RULE3
              COUNT_VALID <= 1'b1;                                        // RULE21
              left_ff     <= opnd_bytes(tbl_mode, tbl_use_y);
              opnd_ff     <= 16'h0000;
              pc_next_ff  <= FETCH_PC + {{(ADDR_W-2){1'b0}},
                              opnd_bytes(tbl_mode, tbl_use_y)} + 1'b1;   // RULE16
              BUSY        <= 1'b1;
            end
          end
        ST_OPND:
          if (FETCH_VALID) begin
            // Big-endian word: first byte lands high
            opnd_ff <= {opnd_ff[7:0], FETCH_BYTE};
            left_ff <= left_ff - 2'd1;
            if (left_ff == 2'd1 && is_indirect(MODE)) begin
              MEM_RD   <= 1'b1;                                           // RULE13
              MEM_ADDR <= {{(ADDR_W-8){1'b0}},
                           (MODE == `OAMD_M_BITREL_I) ? opnd_ff[7:0] : FETCH_BYTE};
            end
          end
        ST_PTR0:
          // Memory answers a cycle late, so the low byte is asked now
          if (is_word_ptr(MODE)) begin
            MEM_RD   <= 1'b1;                                             // RULE15
            MEM_ADDR <= MEM_ADDR + {{(ADDR_W-1){1'b0}}, 1'b1};
          end
        ST_PTR1: begin
          // Byte pointer or high byte of word pointer
          ptr_hi_ff <= MEM_DATA;
          if (!is_word_ptr(MODE)) begin
            case (MODE)
              `OAMD_M_INDX_S: EA <= {{(ADDR_W-9){1'b0}},
                                     short_index_sum(MEM_DATA, idx_val)};
              `OAMD_M_REL_I:  EA <= rel_target(pc_next_ff, MEM_DATA);
              default:        EA <= page_zero(MEM_DATA);                  // RULE14
            endcase
            EA_VALID     <= 1'b1;
            BUSY         <= 1'b0;
            pre_y_ff     <= 1'b0;
            pre_ind_ff   <= 1'b0;
            pre_ind_y_ff <= 1'b0;
          end
        end
        ST_PTR2: begin
          // Low byte of the word pointer arrives now
          if (MODE == `OAMD_M_INDX_L)
            EA <= long_index_sum({ptr_hi_ff, MEM_DATA}, idx_val);
          else
            EA <= {ptr_hi_ff, MEM_DATA};                                  // RULE15 RULE2
          EA_VALID     <= 1'b1;
          BUSY         <= 1'b0;
          pre_y_ff     <= 1'b0;
          pre_ind_ff   <= 1'b0;
          pre_ind_y_ff <= 1'b0;
        end
        ST_DONE:
          // Indirect modes have already reported from the pointer states
          if (!is_indirect(MODE)) begin
            EA           <= calc_ea;
            IMM_DATA     <= opnd_ff[7:0];                                 // RULE6
            EA_VALID     <= 1'b1;
            BUSY         <= 1'b0;
            pre_y_ff     <= 1'b0;
            pre_ind_ff   <= 1'b0;
            pre_ind_y_ff <= 1'b0;
          end
        default: BUSY <= 1'b0;
      endcase
    end
  end

endmodule // oamd_decoder

`default_nettype wire

// ### dv/oamd_decoder_props.sv
/*
  Port checker for the addressing-mode decoder, bound onto its top.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "oamd_consts.vh"
module oamd_decoder_props #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input wire logic                    CLK_SYS,
  input wire logic                    RESET_N,
  // Pointer reads
  input wire logic                    MEM_RD,
  input wire logic [ADDR_W-1:0]       MEM_ADDR,
  // Decode results
  input wire logic [`OAMD_MODE_W-1:0] MODE,
  input wire logic [1:0]              OPND_COUNT,
  input wire logic                    COUNT_VALID,
  input wire logic                    SHORT_ONLY,
  input wire logic                    BUSY,
  input wire logic [ADDR_W-1:0]       EA,
  input wire logic                    EA_VALID
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  inh_count_a: assert property (
    COUNT_VALID && MODE == `OAMD_M_INH |-> OPND_COUNT == 2'h0)
    else $error("inherent operand count wrong");
  long_count_a: assert property (
    COUNT_VALID && (MODE == `OAMD_M_DIR_L || MODE == `OAMD_M_IDX_L) |-> OPND_COUNT == 2'h2)
    else $error("long operand count wrong");
  ptr_count_a: assert property (
    COUNT_VALID && (MODE == `OAMD_M_IND_S || MODE == `OAMD_M_IND_L) |-> OPND_COUNT == 2'h1)
    else $error("indirect operand count wrong");
  count_first_a: assert property (
    COUNT_VALID |-> BUSY && !EA_VALID ##1 !COUNT_VALID)
    else $error("count not announced ahead of address");
  ea_done_a: assert property (
    EA_VALID |-> !BUSY ##1 !EA_VALID)
    else $error("result pulse or busy wrong");
  page_zero_a: assert property (
    EA_VALID && (MODE == `OAMD_M_DIR_S || MODE == `OAMD_M_IDX_0 || MODE == `OAMD_M_IND_S
    || MODE == `OAMD_M_BIT_D || MODE == `OAMD_M_BIT_I) |-> EA[15:8] == 8'h00)
    else $error("short address left page zero");
  short_span_a: assert property (
    EA_VALID && SHORT_ONLY |-> EA <= 16'h01FE)
    else $error("short-only address beyond 1FE");
  ptr_page_a: assert property (
    MEM_RD |-> BUSY && MEM_ADDR <= 16'h0100)
    else $error("pointer read outside page zero");
  word_ptr_a: assert property (
    $rose(MEM_RD) && (MODE == `OAMD_M_IND_L || MODE == `OAMD_M_INDX_L)
    |=> MEM_RD && MEM_ADDR == $past(MEM_ADDR) + 16'h0001)
    else $error("word pointer low byte not read next");
  ptr_read_a: assert property (
    MEM_RD && MODE != `OAMD_M_BITREL_I |-> ##[1:3] EA_VALID)
    else $error("address late after pointer read");

  cover property (EA_VALID && MODE == `OAMD_M_IND_L);
  cover property (MEM_RD ##1 MEM_RD);
  cover property (COUNT_VALID && OPND_COUNT == 2'h2);
endmodule // oamd_decoder_props

bind oamd_decoder oamd_decoder_props #(.ADDR_W(ADDR_W)) oamd_decoder_props_inst (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
  .MODE(MODE), .OPND_COUNT(OPND_COUNT), .COUNT_VALID(COUNT_VALID),
  .SHORT_ONLY(SHORT_ONLY), .BUSY(BUSY), .EA(EA), .EA_VALID(EA_VALID));
`default_nettype wire

// ### dv/oamd_mem_model.sv
/*
  Page-zero pointer memory seen by the decoder's read port.
  Assumes the bench preloads mem; data one cycle after a read.
*/
`timescale 1ns/1ns
`default_nettype none
module oamd_mem_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Read port
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output var  logic [7:0]  mem_data
);
  logic [7:0] mem [0:255];

  // Outside the answer cycle the bus flips, so stale data never matches
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      mem_data <= 8'h00;
    end else if (mem_rd) begin
      mem_data <= mem[mem_addr[7:0]];
    end else begin
      mem_data <= ~mem_data;
    end
  end
endmodule // oamd_mem_model
`default_nettype wire

// ### dv/operand_address_mode_decoder_tb_top.sv
/*
  Self-checking bench for the addressing-mode decoder.
  Assumes a prompt fetch stream and the pointer memory model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "oamd_consts.vh"
module operand_address_mode_decoder_tb_top;
  logic        clk_sys     = 1'b0;
  logic        reset_n     = 1'b0;
  logic        clk_en      = 1'b1;
  logic        fetch_valid = 1'b0;
  logic [7:0]  fetch_byte  = 8'h00;
  logic [15:0] fetch_pc    = 16'h4000;
  logic [7:0]  reg_x       = 8'h00;
  logic [7:0]  reg_y       = 8'h00;
  logic        mem_rd, count_valid, use_y, short_only, busy, ea_valid;
  logic [15:0] mem_addr, ea;
  logic [7:0]  mem_data, imm_data;
  logic [4:0]  mode;
  logic [1:0]  opnd_count;
  integer      miscompares = 0;
  integer      checks      = 0;

  always #10 clk_sys = ~clk_sys;

  oamd_decoder oamd_decoder_inst (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(clk_en), .FETCH_VALID(fetch_valid),
    .FETCH_BYTE(fetch_byte), .FETCH_PC(fetch_pc), .REG_X(reg_x), .REG_Y(reg_y),
    .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .MODE(mode),
    .OPND_COUNT(opnd_count), .COUNT_VALID(count_valid), .USE_Y(use_y),
    .SHORT_ONLY(short_only), .BUSY(busy), .EA(ea), .IMM_DATA(imm_data), .EA_VALID(ea_valid));
  oamd_mem_model oamd_mem_model_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_data(mem_data));

  task automatic chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      checks++;
      if (got !== exp) begin
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
        miscompares++;
      end
    end
  endtask

  // pre[8] marks a prefix; lat 0 skips the latency figure
  task automatic instr(input [8:0] pre, input [7:0] op, input [1:0] n, input [15:0] ops,
                       input [4:0] em, input [15:0] eea, input integer lat, input ey);
    integer i;
    begin
      @(negedge clk_sys);
      fetch_valid = 1'b1;
      if (pre[8]) begin
        fetch_byte = pre[7:0];
        @(negedge clk_sys);
      end
      fetch_byte = op;
      @(negedge clk_sys);
      chk("count_valid", 16'h0001, 16'(count_valid));
      chk("opnd_count", 16'(n), 16'(opnd_count));
      chk("mode", 16'(em), 16'(mode));
      for (i = 0; i < n; i++) begin
        fetch_byte = (n == 2'h2 && i == 0) ? ops[15:8] : ops[7:0];
        @(negedge clk_sys);
      end
      fetch_valid = 1'b0;
      // Latency counts from the cycle in which the last byte stood
      i = 1;
      // Bounded wait keeps a silent design from hanging the run
      while (ea_valid !== 1'b1 && i < 9) begin
        @(negedge clk_sys);
        i++;
      end
      if (lat != 0) chk("latency", 16'(lat), 16'(i));
      chk("ea_valid", 16'h0001, 16'(ea_valid));
      chk("ea", eea, ea);
      chk("use_y", 16'(ey), 16'(use_y));
    end
  endtask

  task automatic t_reset;
    begin
      chk("busy", 16'h0000, 16'(busy));
      chk("ea", 16'h0000, ea);
      chk("mode", 16'h0000, 16'(mode));
    end
  endtask

  task automatic t_inh_imm;
    begin
      instr(9'h000, 8'h4C, 2'h0, 16'h0000, `OAMD_M_INH, 16'h0000, 2, 1'b0);
      instr(9'h000, 8'hA6, 2'h1, 16'h0055, `OAMD_M_IMM, 16'h0000, 2, 1'b0);
      chk("imm_data", 16'h0055, 16'(imm_data));
    end
  endtask

  task automatic t_direct;
    begin
      instr(9'h000, 8'hC6, 2'h2, 16'h1234, `OAMD_M_DIR_L, 16'h1234, 2, 1'b0);
      instr(9'h000, 8'h3C, 2'h1, 16'h0080, `OAMD_M_DIR_S, 16'h0080, 2, 1'b0);
      chk("short_only", 16'h0001, 16'(short_only));
      instr(9'h000, 8'hB6, 2'h1, 16'h00FF, `OAMD_M_DIR_S, 16'h00FF, 2, 1'b0);
      chk("short_only", 16'h0000, 16'(short_only));
    end
  endtask

  task automatic t_indexed;
    begin
      reg_x = 8'hFF;
      reg_y = 8'h81;
      instr(9'h000, 8'hE6, 2'h1, 16'h00FF, `OAMD_M_IDX_S, 16'h01FE, 2, 1'b0);
      reg_x = 8'h20;
      instr(9'h000, 8'hD6, 2'h2, 16'hFFF0, `OAMD_M_IDX_L, 16'h0010, 2, 1'b0);
      reg_x = 8'hC3;
      instr(9'h000, 8'hF6, 2'h0, 16'h0000, `OAMD_M_IDX_0, 16'h00C3, 2, 1'b0);
      instr(9'h000, 8'h6C, 2'h1, 16'h0010, `OAMD_M_IDX_S, 16'h00D3, 2, 1'b0);
      instr(9'h000, 8'h7C, 2'h0, 16'h0000, `OAMD_M_IDX_0, 16'h00C3, 2, 1'b0);
      chk("short_only", 16'h0001, 16'(short_only));
      instr(9'h190, 8'hE6, 2'h1, 16'h0010, `OAMD_M_IDX_S, 16'h0091, 2, 1'b1);
      instr(9'h190, 8'hF6, 2'h0, 16'h0000, `OAMD_M_IDX_0, 16'h0081, 2, 1'b1);
    end
  endtask

  task automatic t_indirect;
    begin
      oamd_mem_model_inst.mem[8'h40] = 8'hAB;
      oamd_mem_model_inst.mem[8'h41] = 8'hCD;
      reg_x = 8'h60;
      reg_y = 8'h70;
      instr(9'h192, 8'hB6, 2'h1, 16'h0040, `OAMD_M_IND_S, 16'h00AB, 3, 1'b0);
      instr(9'h192, 8'hC6, 2'h1, 16'h0040, `OAMD_M_IND_L, 16'hABCD, 4, 1'b0);
      instr(9'h192, 8'hE6, 2'h1, 16'h0040, `OAMD_M_INDX_S, 16'h010B, 3, 1'b0);
      instr(9'h191, 8'hE6, 2'h1, 16'h0040, `OAMD_M_INDX_S, 16'h011B, 3, 1'b1);
      instr(9'h192, 8'hD6, 2'h1, 16'h0040, `OAMD_M_INDX_L, 16'hAC2D, 4, 1'b0);
    end
  endtask

  // Next instruction sits at opcode address plus two
  task automatic t_relative;
    begin
      oamd_mem_model_inst.mem[8'h50] = 8'hFE;
      instr(9'h000, 8'h27, 2'h1, 16'h0080, `OAMD_M_REL_D, 16'h3F82, 2, 1'b0);
      instr(9'h000, 8'h27, 2'h1, 16'h007F, `OAMD_M_REL_D, 16'h4081, 2, 1'b0);
      instr(9'h192, 8'h27, 2'h1, 16'h0050, `OAMD_M_REL_I, 16'h4000, 3, 1'b0);
    end
  endtask

  task automatic t_bit;
    begin
      instr(9'h000, 8'h10, 2'h1, 16'h0022, `OAMD_M_BIT_D, 16'h0022, 2, 1'b0);
      instr(9'h192, 8'h10, 2'h1, 16'h0050, `OAMD_M_BIT_I, 16'h00FE, 3, 1'b0);
      instr(9'h000, 8'h00, 2'h2, 16'h3305, `OAMD_M_BITREL_D, 16'h0033, 2, 1'b0);
      instr(9'h192, 8'h00, 2'h2, 16'h4005, `OAMD_M_BITREL_I, 16'h00AB, 0, 1'b0);
    end
  endtask

  // Frozen clock enable takes no byte; reset mid-run drops a prefix
  task automatic t_freeze_reset;
    begin
      @(negedge clk_sys);
      clk_en      = 1'b0;
      fetch_valid = 1'b1;
      fetch_byte  = `OAMD_PRE_IND;
      repeat (3) @(negedge clk_sys);
      chk("frozen busy", 16'h0000, 16'(busy));
      clk_en = 1'b1;
      @(negedge clk_sys);
      chk("prefix busy", 16'h0001, 16'(busy));
      fetch_valid = 1'b0;
      reset_n     = 1'b0;
      @(negedge clk_sys);
      chk("reset busy", 16'h0000, 16'(busy));
      chk("reset ea", 16'h0000, ea);
      reset_n = 1'b1;
      instr(9'h000, 8'hB6, 2'h1, 16'h0044, `OAMD_M_DIR_S, 16'h0044, 2, 1'b0);
    end
  endtask

  task automatic stop_test;
    begin
      if (miscompares == 0 && checks > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (4) @(negedge clk_sys);
    t_reset();
    reset_n = 1'b1;
    t_inh_imm();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_bit();
    t_freeze_reset();
    stop_test();
  end

  // About 25 instructions of under 12 cycles each; wide margin
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
endmodule // operand_address_mode_decoder_tb_top
`default_nettype wire
